// *** fcis_pkg.sv ***
// Package with register map, field layout and timing constants of the flash event block.
package fcis_pkg;

    // Register byte offsets on the Avalon-MM bus.
    localparam logic [7:0] FCIS_OFF_CMD = 8'h08;
    localparam logic [7:0] FCIS_OFF_RAW = 8'h0C;
    localparam logic [7:0] FCIS_OFF_MASK = 8'h10;
    localparam logic [7:0] FCIS_OFF_MCLR = 8'h14;

    // Event bit positions, shared by the status, mask and clear registers.
    localparam int FCIS_BIT_ACC = 0;
    localparam int FCIS_BIT_PRG = 1;
    localparam int FCIS_NSRC = 2;

    // Command register control bits.
    localparam int FCIS_CMD_WRITE = 0;
    localparam int FCIS_CMD_ERASE = 1;
    localparam int FCIS_CMD_MERASE = 2;

    // Reset values.
    localparam logic [1:0] FCIS_RST_RAW = 2'h0;
    localparam logic [1:0] FCIS_RST_MASK = 2'h0;

    // Clock rate and the longest page erase time.
    localparam longint FCIS_CLK_HZ = 250000000;
    localparam longint FCIS_ERASE_MS = 25;
    localparam int FCIS_ERASE_CYC = int'((FCIS_ERASE_MS * FCIS_CLK_HZ) / 1000);

    // Bus request carried as one packed group.
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } fcis_req_t;

    typedef enum logic [1:0] {
        FCIS_IDLE = 2'b01,
        FCIS_BUSY = 2'b10
    } fcis_state_t;

endpackage

// *** fcis_ctrl.sv ***
// Flash controller event status, mask and interrupt logic with an Avalon-MM slave.
`timescale 1ns/100ps
// Behaviour
// RULE_01: raw status at 0x00C holds every pending event, masked or not.
// RULE_02: interrupt output high only while some raw event has its mask bit set; irq_o follows a mask write one cycle late.
// RULE_03: mask register at 0x010 holds one enable bit per source.
// RULE_04: masked status at 0x014 reads raw AND mask per source.
// RULE_05: writing one to masked status clears raw bit; zeros leave bits alone.
// RULE_06: bit 1 is program or erase done; bit 0 is protection violation.
// RULE_07: a program or erase cycle starts only on a command register write.
// RULE_08: page erase lasts up to 25 ms; its control bit reads one meanwhile.
module fcis_ctrl
    import fcis_pkg::*;
#(
    parameter int ERASE_CYC = FCIS_ERASE_CYC
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic access_violation_i,
    input wire logic program_done_i,
    output logic irq_o
);

    fcis_req_t req;
    logic [1:0] raw_ff;
    logic [1:0] mask_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic wait_ff;
    logic nxt_ack;
    logic irq_ff;
    logic [2:0] cmd_ff;
    logic [31:0] cnt_ff;
    fcis_state_t state_ff;
    logic [1:0] viol_sync_ff;
    logic [1:0] done_sync_ff;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic wr_take;
    logic rd_take;
    logic cmd_go;
    logic busy_done;

    // Decodes a byte address to a match against one register offset.
    function automatic logic fcis_hit(input logic [7:0] addr, input logic [7:0] off);
        fcis_hit = (addr == off);
    endfunction

    assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                   writedata: avs_writedata_i};

    // One wait cycle per access: a request is taken on the edge where ack is low.
    assign wr_take = clk_en_i && req.write && !ack_ff;
    assign rd_take = clk_en_i && req.read && !ack_ff;
    assign nxt_ack = (req.read || req.write) && !ack_ff;
    // Waitrequest has its own flop so the bus sees no gate delay behind the clock edge.
    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o = rdata_ff;
    assign irq_o = irq_ff;

    // Acknowledge flop; it drops after one cycle so back-to-back requests each wait once.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ack_ff <= 1'b0;
            wait_ff <= 1'b1;
        end
        else if (clk_en_i)
        begin
            ack_ff <= nxt_ack;
            wait_ff <= !nxt_ack;
        end
    end

    // Event inputs come from outside logic, so they pass two flops first.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            viol_sync_ff <= 2'h0;
            done_sync_ff <= 2'h0;
        end
        else if (clk_en_i)
        begin
            viol_sync_ff <= {viol_sync_ff[0], access_violation_i};
            done_sync_ff <= {done_sync_ff[0], program_done_i};
        end
    end

    // A command write starts a cycle only when one is not already running.
    assign cmd_go = wr_take && fcis_hit(req.address, FCIS_OFF_CMD)
                    && (state_ff == FCIS_IDLE) && (req.writedata[2:0] != 3'h0); // see RULE_07
    assign busy_done = (state_ff == FCIS_BUSY) && (cnt_ff == 32'h0);

    // Program/erase cycle timer; the control bits read one until it expires.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_ff <= FCIS_IDLE;
            cnt_ff <= 32'h0;
            cmd_ff <= 3'h0;
        end
        else if (clk_en_i)
        begin
            case (state_ff)
                FCIS_IDLE:
                begin
                    if (cmd_go)
                    begin
                        state_ff <= FCIS_BUSY; // see RULE_07
                        cmd_ff <= req.writedata[2:0];
                        cnt_ff <= 32'(ERASE_CYC - 1); // see RULE_08
                    end
                end
                FCIS_BUSY:
                begin
                    if (cnt_ff == 32'h0)
                    begin
                        state_ff <= FCIS_IDLE;
                        cmd_ff <= 3'h0; // see RULE_08
                    end
                    else
                        cnt_ff <= cnt_ff - 32'h1;
                end
                default:
                    state_ff <= FCIS_IDLE;
            endcase
        end
    end

    // Event sources; an external done pulse also counts as a program event.
    assign ev_set[FCIS_BIT_PRG] = busy_done || done_sync_ff[1]; // see RULE_06
    assign ev_set[FCIS_BIT_ACC] = viol_sync_ff[1]; // see RULE_06
    assign ev_clr = (wr_take && fcis_hit(req.address, FCIS_OFF_MCLR))
                    ? req.writedata[1:0] : 2'h0; // see RULE_05

    // Raw status: a set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            raw_ff <= FCIS_RST_RAW;
        else if (clk_en_i)
            raw_ff <= (raw_ff & ~ev_clr) | ev_set; // see RULE_01 see RULE_05
    end

    // Mask register.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            mask_ff <= FCIS_RST_MASK;
        else if (wr_take && fcis_hit(req.address, FCIS_OFF_MASK))
            mask_ff <= req.writedata[1:0]; // see RULE_03
    end

    // Interrupt output is registered from the next raw value and the current mask value.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_ff <= 1'b0;
        else if (clk_en_i)
            irq_ff <= |(((raw_ff & ~ev_clr) | ev_set) & mask_ff); // see RULE_02
    end

    // Read data; unmapped addresses read zero.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_ff <= 32'h0;
        else if (rd_take)
        begin
            case (req.address)
                FCIS_OFF_CMD: rdata_ff <= {29'h0, cmd_ff}; // see RULE_08
                FCIS_OFF_RAW: rdata_ff <= {30'h0, raw_ff}; // see RULE_01
                FCIS_OFF_MASK: rdata_ff <= {30'h0, mask_ff}; // see RULE_03
                FCIS_OFF_MCLR: rdata_ff <= {30'h0, raw_ff & mask_ff}; // see RULE_04
                default: rdata_ff <= 32'h0;
            endcase
        end
    end

    // Assertions.
    chk_irq_matches_mask: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i |=> (irq_o == |($past(((raw_ff & ~ev_clr) | ev_set)) & $past(mask_ff)))) // see RULE_02
        else $error("interrupt level differs from masked status");

    chk_clear_raw_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && ev_clr[FCIS_BIT_ACC] && !ev_set[FCIS_BIT_ACC]) |=> !raw_ff[FCIS_BIT_ACC]) // see RULE_05
        else $error("write one did not clear violation bit");

    chk_zero_keeps: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && !ev_clr[FCIS_BIT_PRG] && raw_ff[FCIS_BIT_PRG]) |=> raw_ff[FCIS_BIT_PRG]) // see RULE_05
        else $error("program bit lost without a clear");

    chk_set_raw: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && viol_sync_ff[1]) |=> raw_ff[FCIS_BIT_ACC]) // see RULE_01
        else $error("violation event not recorded");

    chk_mask_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_take && req.address == FCIS_OFF_MASK) |=> mask_ff == $past(req.writedata[1:0])) // see RULE_03
        else $error("mask write not stored");

    chk_masked_read: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_take && req.address == FCIS_OFF_MCLR)
        |=> avs_readdata_o == {30'h0, $past(raw_ff) & $past(mask_ff)}) // see RULE_04
        else $error("masked status read wrong");

    sequence fcis_start_s;
        cmd_go;
    endsequence

    chk_cmd_busy: assert property (@(posedge clk_i) disable iff (reset_i)
        fcis_start_s |=> (state_ff == FCIS_BUSY) && (cmd_ff != 3'h0)) // see RULE_08
        else $error("command did not start a busy cycle");

    chk_no_spurious: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_ff == FCIS_IDLE && !cmd_go) |=> state_ff == FCIS_IDLE) // see RULE_07
        else $error("cycle started without command write");

    chk_done_event: assert property (@(posedge clk_i) disable iff (reset_i)
        (clk_en_i && busy_done) |=> raw_ff[FCIS_BIT_PRG] && cmd_ff == 3'h0) // see RULE_06
        else $error("cycle end did not raise program event");

    // Waitrequest drops for exactly one running cycle per access.
    chk_wait_pulse: assert property (@(posedge clk_i) disable iff (reset_i) // see RULE_03
        (clk_en_i && !avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest stayed low");

    // A program event in the same cycle as its clear must still be recorded.
    chk_set_wins: assert property (@(posedge clk_i) disable iff (reset_i) // see RULE_06
        (clk_en_i && ev_set[FCIS_BIT_PRG]) |=> raw_ff[FCIS_BIT_PRG])
        else $error("program event lost");

    // With the clock enable low the status must not move.
    chk_freeze_raw: assert property (@(posedge clk_i) disable iff (reset_i) // see RULE_01
        !clk_en_i |=> raw_ff == $past(raw_ff))
        else $error("status changed while frozen");

    // Command reads return the control bits of the running cycle.
    chk_cmd_read: assert property (@(posedge clk_i) disable iff (reset_i) // see RULE_08
        (rd_take && req.address == FCIS_OFF_CMD) |=> avs_readdata_o == {29'h0, $past(cmd_ff)})
        else $error("command read wrong");

endmodule

// *** fcis_event_model.sv ***
// Model of the flash engine and protection logic that raise the block's event inputs.
`timescale 1ns/100ps
module fcis_event_model
(
    input wire logic clk_i,
    input wire logic [1:0] fire_i,
    output logic access_violation_o,
    output logic program_done_o
);
    // Each requested event is registered, so a one-cycle request gives a one-cycle pulse, the shortest the real sources give.
    always_ff @(posedge clk_i)
    begin
        access_violation_o <= fire_i[0];
        program_done_o <= fire_i[1];
    end
endmodule

// *** test_fcis_ctrl.sv ***
// Self-checking testbench of the flash event status and interrupt block.
`timescale 1ns/100ps
module test_fcis_ctrl;
    import fcis_pkg::*;
    localparam int ECYC = 20;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} fcis_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [1:0] fire = 2'h0;
    logic en = 1'b1;
    logic [31:0] rdat;
    logic wait_o;
    logic irq;
    logic acc;
    logic prg;
    logic [31:0] got;
    int err_total = 0;
    int cmp_count = 0;
    // Reset values, mask width, an unmapped address and a mask restored to zero.
    fcis_row_t rows [8] = '{
        '{FCIS_OFF_RAW, 1'b0, 32'h0, 32'h0}, '{FCIS_OFF_MASK, 1'b0, 32'h0, 32'h0},
        '{FCIS_OFF_MCLR, 1'b0, 32'h0, 32'h0}, '{FCIS_OFF_MASK, 1'b1, 32'hFFFFFFFF, 32'h0},
        '{FCIS_OFF_MASK, 1'b0, 32'h0, 32'h3}, '{8'h20, 1'b1, 32'h5, 32'h0},
        '{8'h20, 1'b0, 32'h0, 32'h0}, '{FCIS_OFF_MASK, 1'b1, 32'h0, 32'h0}};

    // The clock inverts every half period of 2 ns.
    initial forever #2 clk_i = ~clk_i;

    fcis_event_model u_src (.clk_i(clk_i), .fire_i(fire), .access_violation_o(acc),
        .program_done_o(prg));

    // The clock enable is driven so that a frozen block can be checked.
    fcis_ctrl #(.ERASE_CYC(ECYC)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(en),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .access_violation_i(acc),
        .program_done_i(prg), .irq_o(irq));

    // One bus access; the request holds until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk_i);
        while (wait_o !== 1'b0)
            @(posedge clk_i);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %0t data %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_irq(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %0t irq %b expected %b", $time, g, e);
        end
    endtask

    // Pulse an event, then allow the two-flop synchroniser delay to pass.
    task automatic fire_ev(input logic [1:0] f);
        @(posedge clk_i);
        fire <= f;
        @(posedge clk_i);
        fire <= 2'h0;
        repeat (5) @(posedge clk_i);
    endtask

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence: table rows first, then events, clears and the erase cycle.
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        chk_irq(irq, 1'b0);
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(got, rows[i].e);
        end
        fire_ev(2'h1);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h1);
        chk_irq(irq, 1'b0);
        bus(1'b0, FCIS_OFF_MCLR, 32'h0);
        chk(got, 32'h0);
        bus(1'b1, FCIS_OFF_MASK, 32'h1);
        bus(1'b0, FCIS_OFF_MCLR, 32'h0);
        chk(got, 32'h1);
        chk_irq(irq, 1'b1);
        bus(1'b1, FCIS_OFF_MCLR, 32'h2);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h1);
        bus(1'b1, FCIS_OFF_MCLR, 32'h1);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h0);
        chk_irq(irq, 1'b0);
        fire_ev(2'h2);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h2);
        bus(1'b1, FCIS_OFF_MCLR, 32'h2);
        bus(1'b1, FCIS_OFF_MASK, 32'h2);
        bus(1'b1, FCIS_OFF_CMD, 32'h2);
        bus(1'b0, FCIS_OFF_CMD, 32'h0);
        chk(got, 32'h2);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h0);
        repeat (ECYC + 5) @(posedge clk_i);
        bus(1'b0, FCIS_OFF_CMD, 32'h0);
        chk(got, 32'h0);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h2);
        chk_irq(irq, 1'b1);
        // A pulse that arrives while the block is frozen never reaches the status.
        bus(1'b1, FCIS_OFF_MCLR, 32'h3);
        @(posedge clk_i);
        en <= 1'b0;
        fire_ev(2'h1);
        en <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h0);
        chk_irq(irq, 1'b0);
        // A reset in mid-run clears a pending, enabled event and the interrupt.
        bus(1'b1, FCIS_OFF_MASK, 32'h1);
        fire_ev(2'h1);
        chk_irq(irq, 1'b1);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk_irq(irq, 1'b0);
        bus(1'b0, FCIS_OFF_RAW, 32'h0);
        chk(got, 32'h0);
        bus(1'b0, FCIS_OFF_MASK, 32'h0);
        chk(got, 32'h0);
        final_report();
    end

    // Watchdog: the sequence needs about 170 cycles, so 5000 means a hang.
    initial
    begin
        #20000;
        err_total++;
        final_report();
    end
endmodule
